// ===== core/startup_map.vh
// Purpose: constants for the clock device start-up sequencer
// Assumes: 250 MHz system clock
// Notes: counts derived from times in their own units
`ifndef STARTUP_MAP_VH
`define STARTUP_MAP_VH
`define CLK_PERIOD_PS 4000
`define MIN_PULSE_NS 200
`define CH_TIMEOUT_DEFAULT 16'h0400
`define XO_STABLE_DEFAULT 16'h0100
`define ST_OFF 3'h0
`define ST_XO_WAIT 3'h1
`define ST_CAL 3'h2
`define ST_PLL 3'h3
`define ST_RUN 3'h4
`define ST_FAIL 3'h5
`define CAL_TIMEOUT_DEFAULT 16'h1000
`endif

// ===== core/output_channel_gate.v
// Purpose: per-channel reset and mute gate for one output channel
// Assumes: supply_good already synchronised, device_run from same clock
// Notes: unmute only after the programmable timeout expires
`include "startup_map.vh"
`timescale 1ns/10ps
module output_channel_gate #(
    parameter CW = 16
) (
    input wire clk_sys,
    input wire rst_n,
    input wire device_run,
    input wire supply_good,
    input wire [CW-1:0] timeout,
    output reg channel_reset,
    output reg channel_mute
);
    reg [CW-1:0] count;

    // ------------------------------------------------------------
    // timeout counter, restarts whenever supply or device drops
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n || !device_run || !supply_good) begin
            count <= {CW{1'b0}};
            channel_reset <= 1'b1;
            channel_mute <= 1'b1;
        end else if (count < timeout) begin
            count <= count + {{(CW-1){1'b0}}, 1'b1};
            channel_reset <= 1'b1;
            channel_mute <= 1'b1;
        end else begin
            channel_reset <= 1'b0;
            channel_mute <= 1'b0; // clean start, no runt pulses
        end
    end
endmodule // output_channel_gate

// ===== core/clock_device_startup_sequencer.v
// Purpose: start-up and reset sequencer for a dual-channel clock device
// Assumes: supply-good and oscillator-stable inputs are asynchronous pins
// Notes: analog thresholds are detected outside; this block sees levels
`include "startup_map.vh"
`timescale 1ns/10ps
module clock_device_startup_sequencer #(
    parameter CHANNELS = 2,
    parameter CW = 16,
    parameter [CW-1:0] XO_STABLE_CYCLES = `XO_STABLE_DEFAULT,
    parameter [CW-1:0] CAL_TIMEOUT = `CAL_TIMEOUT_DEFAULT
) (
    input wire clk_sys,
    input wire rst_n,
    input wire power_down_n,
    input wire digital_core_supply,
    input wire [CHANNELS-1:0] output_channel_supply,
    input wire xo_stable,
    input wire soft_reset,
    input wire cal_done,
    input wire cal_fail,
    input wire pll_locked,
    input wire [CHANNELS*CW-1:0] channel_timeout,
    output reg device_reset,
    output reg functions_enable,
    output reg serial_enable,
    output reg cal_start,
    output reg pll_start,
    output reg startup_fail,
    output reg [CHANNELS-1:0] channel_reset,
    output reg [CHANNELS-1:0] channel_mute
);
    // shortest low pulse on power_down_n, in cycles, rounded up
    // a host pulse below this may fall between samples and be lost
    localparam integer MIN_PULSE_CYC =
        (`MIN_PULSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // pin synchronisers: three stages, change once stages 2 and 3 agree
    // ------------------------------------------------------------
    reg [2:0] pdn_s;
    reg [2:0] core_s;
    reg [2:0] xo_s;
    reg pdn_q;
    reg core_q;
    reg xo_q;
    reg [CHANNELS-1:0] sup_s1;
    reg [CHANNELS-1:0] sup_s2;
    reg [CHANNELS-1:0] sup_s3;
    reg [CHANNELS-1:0] sup_q;

    // first stage is read only by the second
    // third stage filters a one-cycle glitch at the cost of a cycle of latency
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pdn_s <= 3'h0;
            core_s <= 3'h0;
            xo_s <= 3'h0;
            pdn_q <= 1'b0;
            core_q <= 1'b0;
            xo_q <= 1'b0;
            sup_s1 <= {CHANNELS{1'b0}};
            sup_s2 <= {CHANNELS{1'b0}};
            sup_s3 <= {CHANNELS{1'b0}};
            sup_q <= {CHANNELS{1'b0}};
        end else begin
            pdn_s <= {pdn_s[1:0], power_down_n};
            core_s <= {core_s[1:0], digital_core_supply};
            xo_s <= {xo_s[1:0], xo_stable};
            sup_s1 <= output_channel_supply;
            sup_s2 <= sup_s1;
            sup_s3 <= sup_s2;
            if (pdn_s[1] == pdn_s[2]) begin
                pdn_q <= pdn_s[2];
            end
            if (core_s[1] == core_s[2]) begin
                core_q <= core_s[2];
            end
            if (xo_s[1] == xo_s[2]) begin
                xo_q <= xo_s[2];
            end
            sup_q <= (sup_s2 & sup_s3) | (sup_q & (sup_s2 | sup_s3));
        end
    end

    // ------------------------------------------------------------
    // power-on reset sequence
    // ------------------------------------------------------------
    reg [2:0] state;
    reg [2:0] next_state;
    reg [CW-1:0] wait_cnt;
    reg pdn_prev;
    wire por_ok = pdn_q & core_q;
    wire pdn_rise = pdn_q & ~pdn_prev;

    // a rising power_down_n forces one off cycle, so a short low pulse
    // still restarts the whole sequence, as por_ok drops with pdn_q as well
    // limitation: a failed calibration stays failed until soft reset or power-down
    // next-state logic; soft reset drops back to oscillator wait
    always @* begin
        next_state = state;
        case (state)
            `ST_OFF: begin
                if (por_ok) begin
                    next_state = `ST_XO_WAIT;
                end
            end
            `ST_XO_WAIT: begin
                if (xo_q && wait_cnt >= XO_STABLE_CYCLES) begin
                    next_state = `ST_CAL;
                end
            end
            `ST_CAL: begin
                if (cal_fail || wait_cnt >= CAL_TIMEOUT) begin
                    next_state = `ST_FAIL;
                end else if (cal_done) begin
                    next_state = `ST_PLL;
                end
            end
            `ST_PLL: begin
                if (pll_locked) begin
                    next_state = `ST_RUN;
                end
            end
            `ST_RUN: begin
                next_state = `ST_RUN;
            end
            `ST_FAIL: begin
                next_state = `ST_FAIL; // stays unlocked until reset
            end
            default: begin
                // unused codes fall back to off
                next_state = `ST_OFF;
            end
        endcase
        if (!por_ok || pdn_rise) begin
            next_state = `ST_OFF;
        end else if (soft_reset && state != `ST_OFF) begin
            next_state = `ST_XO_WAIT;
        end
    end

    // state register and outputs, all from flops
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= `ST_OFF;
            wait_cnt <= {CW{1'b0}};
            pdn_prev <= 1'b0;
            device_reset <= 1'b1;
            functions_enable <= 1'b0;
            serial_enable <= 1'b0;
            cal_start <= 1'b0;
            pll_start <= 1'b0;
            startup_fail <= 1'b0;
        end else begin
            state <= next_state;
            pdn_prev <= pdn_q;
            // wait counter restarts on every state change
            // it saturates instead of wrapping, so a long wait never
            // looks like a fresh start to the threshold compares
            if (next_state != state || !xo_q) begin
                wait_cnt <= {CW{1'b0}};
            end else if (wait_cnt != {CW{1'b1}}) begin
                wait_cnt <= wait_cnt + {{(CW-1){1'b0}}, 1'b1};
            end
            device_reset <= (next_state == `ST_OFF);
            functions_enable <= (next_state == `ST_RUN);
            // serial access follows por_ok alone, not the sequencer state
            serial_enable <= por_ok;
            // one-cycle pulse on entry to calibration
            cal_start <= (next_state == `ST_CAL) && (state != `ST_CAL);
            pll_start <= (next_state == `ST_PLL) && (state != `ST_PLL);
            startup_fail <= (next_state == `ST_FAIL);
        end
    end

    // ------------------------------------------------------------
    // output channel gates
    // ------------------------------------------------------------
    // channels leave reset only once the device runs; a late channel
    // supply restarts that channel's own timeout without touching the rest
    wire device_run = functions_enable;
    wire [CHANNELS-1:0] ch_rst;
    wire [CHANNELS-1:0] ch_mute;
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : gen_ch
            output_channel_gate #(
                .CW(CW)
            ) u_gate (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .device_run(device_run),
                .supply_good(sup_q[g]),
                .timeout(channel_timeout[g*CW +: CW]),
                .channel_reset(ch_rst[g]),
                .channel_mute(ch_mute[g])
            );
        end
    endgenerate

    // retime so the top outputs come straight from flops
    // costs one cycle of latency on every channel edge except the one forced by device_run dropping
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            channel_reset <= {CHANNELS{1'b1}};
            channel_mute <= {CHANNELS{1'b1}};
        end else begin
            channel_reset <= ch_rst | {CHANNELS{~device_run}};
            channel_mute <= ch_mute | {CHANNELS{~device_run}};
        end
    end
endmodule // clock_device_startup_sequencer

// ===== verification/startup_chk.sv
// Purpose: port checker for the start-up sequencer
// Assumes: one clock, synchronous reset
// Notes: windows allow for the pin synchronisers
`timescale 1ns/10ps
module startup_chk #(parameter CHANNELS = 2) (
    input wire clk_sys,
    input wire rst_n,
    input wire power_down_n,
    input wire digital_core_supply,
    input wire xo_stable,
    input wire soft_reset,
    input wire cal_done,
    input wire device_reset,
    input wire functions_enable,
    input wire serial_enable,
    input wire cal_start,
    input wire pll_start,
    input wire [CHANNELS-1:0] output_channel_supply,
    input wire [CHANNELS-1:0] channel_mute
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // six low samples: three sync stages, the pdn_q agreement flop, then the output flop
    property p_pdn_off;
        !power_down_n [*6] |-> device_reset && !serial_enable && !functions_enable; endproperty
    a_pdn_off: assert property (p_pdn_off) else $error("active while down");
    property p_por;
        $fell(device_reset) |-> $past(power_down_n, 3) && digital_core_supply; endproperty
    a_por: assert property (p_por) else $error("reset left early");
    // seven samples: sync, gate flop and output retime all lie in between
    property p_held; !output_channel_supply[1] [*7] |-> channel_mute[1]; endproperty
    a_held: assert property (p_held) else $error("channel not muted");
    property p_unmute; $fell(channel_mute[0]) |-> functions_enable; endproperty
    a_unmute: assert property (p_unmute) else $error("unmuted outside run");
    property p_cal_xo; cal_start |-> xo_stable && $past(xo_stable, 3); endproperty
    a_cal_xo: assert property (p_cal_xo) else $error("calibration on unstable xo");
    property p_cal_pulse; cal_start |=> !cal_start; endproperty
    a_cal_pulse: assert property (p_cal_pulse) else $error("start not a pulse");
    property p_soft; soft_reset && functions_enable |-> ##[1:40] cal_start; endproperty
    a_soft: assert property (p_soft) else $error("soft reset ignored");
    property p_pll; pll_start |-> $past(cal_done) || $past(cal_done, 2); endproperty
    a_pll: assert property (p_pll) else $error("pll start without calibration");
endmodule // startup_chk
bind clock_device_startup_sequencer startup_chk #(.CHANNELS(CHANNELS)) chk_u (.clk_sys, .rst_n,
    .power_down_n, .digital_core_supply, .xo_stable, .soft_reset, .cal_done, .device_reset,
    .functions_enable, .serial_enable, .cal_start, .pll_start, .output_channel_supply,
    .channel_mute);

// ===== verification/host_model.sv
// Purpose: host and analog partner of the start-up sequencer
// Assumes: answers land 1 ns after a clock edge
// Notes: calibration results are one-cycle pulses so neither is ever stale; pll_locked is a level
`timescale 1ns/10ps
module host_model (
    input wire clk_sys,
    input wire cal_start,
    input wire pll_start,
    output reg power_down_n = 1'b0,
    output reg cal_done = 1'b0,
    output reg cal_fail = 1'b0,
    output reg pll_locked = 1'b0
);
    reg fail_mode = 1'b0;
    // calibration answers 3 cycles on, lock follows pll start
    always @(posedge clk_sys) begin
        if (cal_start) begin
            pll_locked <= 1'b0;
            cal_done <= #13 !fail_mode;
            cal_fail <= #13 fail_mode;
            cal_done <= #17 1'b0;
            cal_fail <= #17 1'b0;
        end
        if (pll_start) pll_locked <= #9 1'b1;
    end
endmodule // host_model

// ===== verification/testbench.sv
// Purpose: self-checking bench for the start-up sequencer
// Assumes: inputs move 1 ns after the rising edge
// Notes: short xo and calibration counts keep the run brief
`timescale 1ns/10ps
module testbench;
    reg clk_sys = 1'b0, rst_n = 1'b0, digital_core_supply = 1'b0, xo_stable = 1'b0;
    reg soft_reset = 1'b0;
    reg [1:0] output_channel_supply = 2'h0;
    wire power_down_n, cal_done, cal_fail, pll_locked, device_reset, functions_enable;
    wire serial_enable, cal_start, pll_start, startup_fail;
    wire [1:0] channel_reset, channel_mute;
    // status: reset, run, serial, fail, channel resets, channel mutes
    wire [7:0] stat = {device_reset, functions_enable, serial_enable, startup_fail,
        channel_reset, channel_mute};
    integer miscompares = 0, n_checks = 0, cycles = 0, n = 0;
    clock_device_startup_sequencer #(.XO_STABLE_CYCLES(16'h0004), .CAL_TIMEOUT(16'h0010))
        dut_u (.clk_sys, .rst_n, .power_down_n, .digital_core_supply, .output_channel_supply,
        .xo_stable, .soft_reset, .cal_done, .cal_fail, .pll_locked, .device_reset,
        .channel_timeout(32'h0010_0008), .functions_enable, .serial_enable, .cal_start,
        .pll_start, .startup_fail, .channel_reset, .channel_mute);
    host_model host_u (.clk_sys, .cal_start, .pll_start, .power_down_n, .cal_done,
        .cal_fail, .pll_locked);
    initial forever #2 clk_sys = ~clk_sys;
    // the whole run needs well under a thousand cycles
    always @(posedge clk_sys) if (++cycles == 5000) end_sim(1'b1);
    task chk(input [7:0] got, input [7:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp) miscompares = miscompares + 1;
    endtask
    // bounded wait; n is left holding the cycles spent
    task wait_bit(input integer idx, input val);
        for (n = 0; stat[idx] !== val && n < 400; n = n + 1) #4;
    endtask
    task t_power_up;
        xo_stable = 1'b1;
        host_u.power_down_n = 1'b1;
        #40 chk(stat, 8'h8f);
        digital_core_supply = 1'b1;
        output_channel_supply = 2'h1;
        wait_bit(0, 1'b0);
        chk(stat, 8'h6a);
    endtask
    task t_late_channel;
        output_channel_supply = 2'h3;
        wait_bit(1, 1'b0);
        chk({7'h0, n >= 16 && n <= 28}, 8'h01);
        chk(stat, 8'h60);
    endtask
    // a channel losing its supply in run is held and muted on its own
    task t_drop_channel;
        output_channel_supply = 2'h1;
        wait_bit(1, 1'b1);
        chk({7'h0, n <= 8}, 8'h01);
        chk(stat, 8'h6a);
        output_channel_supply = 2'h3;
        wait_bit(1, 1'b0);
        chk(stat, 8'h60);
    endtask
    // a failed calibration raises startup_fail and a soft reset recovers it
    task t_fail;
        host_u.fail_mode = 1'b1;
        soft_reset = 1'b1;
        #4 soft_reset = 1'b0;
        wait_bit(4, 1'b1);
        chk({3'h0, stat[6:4], stat[1:0]}, 8'h0f);
        host_u.fail_mode = 1'b0;
        soft_reset = 1'b1;
        #4 soft_reset = 1'b0;
        wait_bit(1, 1'b0);
        chk(stat, 8'h60);
    endtask
    task t_pdn;
        host_u.power_down_n = 1'b0;
        #220 chk(stat, 8'h8f);
        host_u.power_down_n = 1'b1;
        wait_bit(1, 1'b0);
        chk(stat, 8'h60);
    endtask
    task end_sim(input late);
        miscompares = miscompares + late;
        if (miscompares == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        t_power_up;
        t_late_channel;
        t_drop_channel;
        t_fail;
        t_pdn;
        end_sim(1'b0);
    end
endmodule // testbench
